// File: rtl/ext_irq_pkg.sv
// Package for the external pin interrupt controller: offsets, fields, resets, carriers.
// Assumes a byte-wide register port with a four-bit word address.
package ext_irq_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_LOW_SENSE  = 4'h0;
  localparam logic [3:0] OFS_L6_SENSE   = 4'h1;
  localparam logic [3:0] OFS_ENABLE     = 4'h2;
  localparam logic [3:0] OFS_FLAGS      = 4'h3;
  localparam logic [3:0] OFS_PC_CTRL    = 4'h4;
  localparam logic [3:0] OFS_PC_FLAG    = 4'h5;
  localparam logic [3:0] OFS_PC_MASK    = 4'h6;
  // Field positions.
  localparam int L6_SENSE_LO_BIT = 4;
  localparam int L6_SENSE_HI_BIT = 5;
  localparam int LINE6_BIT       = 6;
  localparam int CHG_ENABLE_BIT  = 0;
  localparam int CHG_FLAG_BIT    = 0;
  // Values after reset.
  localparam logic [7:0] RST_LOW_SENSE = 8'h00;
  localparam logic [1:0] RST_L6_SENSE  = 2'h0;
  localparam logic [7:0] RST_ENABLE    = 8'h00;
  localparam logic [7:0] RST_PC_MASK   = 8'h00;
  // Sense encodings.
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // One bit per vector: line 6, lines 3..0, pin-change group.
  typedef struct packed {
    logic       line6;
    logic [3:0] low;
    logic       chg;
  } irq_vec_t;
  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [7:0]  wdata;
  } reg_req_t;
endpackage

// File: rtl/external_pin_interrupts.sv
// External pin interrupt controller: line 6, lines 3..0 and an eight-pin change group.
// Assumes pins arrive asynchronously and the processor acknowledges each vector it runs.
`timescale 1ns/1ps
module external_pin_interrupts
  import ext_irq_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             resetn,
  // Register port.
  input  wire reg_req_t         reg_req,
  output logic      [7:0]       rdata_ff,
  // Pins.
  input  wire logic             ext_line6_pin,
  input  wire logic [3:0]       ext_lines_low_pins,
  input  wire logic [7:0]       change_group_pins,
  // Processor side.
  input  wire logic             global_irq_en,
  input  wire logic             io_clk_run,
  input  wire logic             sleep_active,
  input  wire irq_vec_t         vector_ack,
  output irq_vec_t              irq_req_ff
);

  function automatic logic sense_hit(input logic [1:0] mode, input logic prev,
                                     input logic cur);
    case (mode)
      SENSE_ANY:  sense_hit = prev ^ cur;
      SENSE_FALL: sense_hit = prev & ~cur;
      SENSE_RISE: sense_hit = ~prev & cur;
      default:    sense_hit = 1'b0;
    endcase
  endfunction

  // Every pin passes two flip-flops before anything reads it.
  logic       l6_meta_ff, l6_sync_ff, l6_prev_ff;
  logic [3:0] low_meta_ff, low_sync_ff, low_prev_ff;
  logic [7:0] chg_meta_ff, chg_sync_ff, chg_prev_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      l6_meta_ff  <= 1'b1;
      l6_sync_ff  <= 1'b1;
      low_meta_ff <= 4'hF;
      low_sync_ff <= 4'hF;
      chg_meta_ff <= 8'h00;
      chg_sync_ff <= 8'h00;
    end
    else
    begin
      l6_meta_ff  <= ext_line6_pin;
      l6_sync_ff  <= l6_meta_ff;
      low_meta_ff <= ext_lines_low_pins;
      low_sync_ff <= low_meta_ff;
      chg_meta_ff <= change_group_pins;
      chg_sync_ff <= chg_meta_ff;
    end
  end

  // Registers.
  logic [7:0] low_sense_ff;
  logic [1:0] l6_sense_ff;
  logic [7:0] enable_ff;
  logic       line6_flag_ff;
  logic [3:0] low_lines_flags_ff;
  logic       change_group_enable_ff;
  logic       change_group_flag_ff;
  logic [7:0] pc_mask_ff;

  logic wr_low_sense, wr_l6_sense, wr_enable, wr_flags;
  logic wr_pc_ctrl, wr_pc_flag, wr_pc_mask;

  always_comb
  begin
    wr_low_sense = 1'b0;
    wr_l6_sense  = 1'b0;
    wr_enable    = 1'b0;
    wr_flags     = 1'b0;
    wr_pc_ctrl   = 1'b0;
    wr_pc_flag   = 1'b0;
    wr_pc_mask   = 1'b0;
    if (reg_req.wr)
    begin
      if (reg_req.addr == OFS_LOW_SENSE)
        wr_low_sense = 1'b1;
      else if (reg_req.addr == OFS_L6_SENSE)
        wr_l6_sense = 1'b1;
      else if (reg_req.addr == OFS_ENABLE)
        wr_enable = 1'b1;
      else if (reg_req.addr == OFS_FLAGS)
        wr_flags = 1'b1;
      else if (reg_req.addr == OFS_PC_CTRL)
        wr_pc_ctrl = 1'b1;
      else if (reg_req.addr == OFS_PC_FLAG)
        wr_pc_flag = 1'b1;
      else if (reg_req.addr == OFS_PC_MASK)
        wr_pc_mask = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_sense_ff           <= RST_LOW_SENSE;
      l6_sense_ff            <= RST_L6_SENSE;
      enable_ff              <= RST_ENABLE;
      change_group_enable_ff <= 1'b0;
      pc_mask_ff             <= RST_PC_MASK;
    end
    else
    begin
      if (wr_low_sense)
        low_sense_ff <= reg_req.wdata;
      if (wr_l6_sense)
        l6_sense_ff <= reg_req.wdata[L6_SENSE_HI_BIT:L6_SENSE_LO_BIT];
      if (wr_enable)
        enable_ff <= {1'b0, reg_req.wdata[LINE6_BIT], 2'b00, reg_req.wdata[3:0]};
      if (wr_pc_ctrl)
        change_group_enable_ff <= reg_req.wdata[CHG_ENABLE_BIT];
      if (wr_pc_mask)
        pc_mask_ff <= reg_req.wdata;
    end
  end

  // Line 6 sampling only advances while the I/O clock runs; in deep sleep no edge is seen.
  logic l6_edge;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      l6_prev_ff <= 1'b1;
    else if (io_clk_run)
      l6_prev_ff <= l6_sync_ff;
  end
  assign l6_edge = io_clk_run && sense_hit(l6_sense_ff, l6_prev_ff, l6_sync_ff);

  // A disabled low line has its buffer off in sleep, seen internally as a low level.
  logic [3:0] low_seen;
  logic [3:0] low_edge;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      low_seen[i] = (sleep_active && !enable_ff[i]) ? 1'b0 : low_sync_ff[i];
      low_edge[i] = sense_hit(low_sense_ff[2*i+:2], low_prev_ff[i], low_seen[i]);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_prev_ff <= 4'hF;
      chg_prev_ff <= 8'h00;
    end
    else
    begin
      low_prev_ff <= low_seen;
      chg_prev_ff <= chg_sync_ff;
    end
  end

  // Group changes need no I/O clock gating, so they keep working in sleep.
  logic chg_event;
  assign chg_event = |((chg_sync_ff ^ chg_prev_ff) & pc_mask_ff);

  // Flags: hardware set beats software or handler clear.
  logic       line6_clr;
  logic [3:0] low_clr;
  logic       chg_clr;
  assign line6_clr = (wr_flags && reg_req.wdata[LINE6_BIT]) || vector_ack.line6;
  assign low_clr   = (wr_flags ? reg_req.wdata[3:0] : 4'h0) | vector_ack.low;
  assign chg_clr   = (wr_pc_flag && reg_req.wdata[CHG_FLAG_BIT]) || vector_ack.chg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      line6_flag_ff <= 1'b0;
    else if (l6_sense_ff == SENSE_LOW)
      line6_flag_ff <= 1'b0;
    else if (l6_edge)
      line6_flag_ff <= 1'b1;
    else if (line6_clr)
      line6_flag_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      low_lines_flags_ff <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (low_sense_ff[2*i+:2] == SENSE_LOW)
          low_lines_flags_ff[i] <= 1'b0;
        else if (low_edge[i])
          low_lines_flags_ff[i] <= 1'b1;
        else if (low_clr[i])
          low_lines_flags_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      change_group_flag_ff <= 1'b0;
    else if (chg_event)
      change_group_flag_ff <= 1'b1;
    else if (chg_clr)
      change_group_flag_ff <= 1'b0;
  end

  // Requests. Pin direction is not looked at, so a driven output still interrupts.
  irq_vec_t nxt_irq_req;
  always_comb
  begin
    nxt_irq_req.line6 = global_irq_en && enable_ff[LINE6_BIT] &&
                        ((l6_sense_ff == SENSE_LOW) ? !l6_sync_ff : line6_flag_ff);
    for (int i = 0; i < 4; i++)
      nxt_irq_req.low[i] = global_irq_en && enable_ff[i] &&
                           ((low_sense_ff[2*i+:2] == SENSE_LOW) ? !low_seen[i]
                                                               : low_lines_flags_ff[i]);
    nxt_irq_req.chg = global_irq_en && change_group_enable_ff && change_group_flag_ff;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_req_ff <= '0;
    else
      irq_req_ff <= nxt_irq_req;
  end

  // Read data stands only in the cycle after the read strobe.
  logic [7:0] rd_val;
  always_comb
  begin
    rd_val = 8'h00;
    if (reg_req.addr == OFS_LOW_SENSE)
      rd_val = low_sense_ff;
    else if (reg_req.addr == OFS_L6_SENSE)
      rd_val = {2'b00, l6_sense_ff, 4'h0};
    else if (reg_req.addr == OFS_ENABLE)
      rd_val = enable_ff;
    else if (reg_req.addr == OFS_FLAGS)
      rd_val = {1'b0, line6_flag_ff, 2'b00, low_lines_flags_ff};
    else if (reg_req.addr == OFS_PC_CTRL)
      rd_val = {7'h00, change_group_enable_ff};
    else if (reg_req.addr == OFS_PC_FLAG)
      rd_val = {7'h00, change_group_flag_ff};
    else if (reg_req.addr == OFS_PC_MASK)
      rd_val = pc_mask_ff;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= reg_req.rd ? rd_val : 8'h00;
  end

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_l6_fall;
    (l6_prev_ff && io_clk_run) ##0 (!l6_sync_ff && l6_sense_ff == SENSE_FALL);
  endsequence

  sequence s_l6_low_enabled;
    (l6_sense_ff == SENSE_LOW) ##0 (!l6_sync_ff && enable_ff[LINE6_BIT] && global_irq_en);
  endsequence

  a_l6_req_gate: assert property (
    irq_req_ff.line6 |-> $past(enable_ff[LINE6_BIT]) && $past(global_irq_en))
    else $error("line 6 request without both enables");

  a_l6_fall_flag: assert property (s_l6_fall |=> line6_flag_ff)
    else $error("line 6 falling edge did not set its flag");

  a_l6_pulse_seen: assert property (
    (io_clk_run && l6_sense_ff == SENSE_ANY && l6_sync_ff != l6_prev_ff) |=> line6_flag_ff)
    else $error("line 6 change was missed");

  a_level_request: assert property (s_l6_low_enabled |=> irq_req_ff.line6)
    else $error("low level did not hold the request");

  a_sense_reserved: assert property (
    (reg_req.rd && reg_req.addr == OFS_L6_SENSE) |=> (rdata_ff[7:6] == 2'b00)
                                                     && (rdata_ff[3:0] == 4'h0))
    else $error("reserved sense bits read non-zero");

  a_level_no_flag: assert property (
    (l6_sense_ff == SENSE_LOW)[*2] |-> !line6_flag_ff)
    else $error("line 6 flag set under level sensing");

  a_w1c_clear: assert property (
    (wr_flags && reg_req.wdata[0] && !low_edge[0]) |=> !low_lines_flags_ff[0])
    else $error("write one did not clear line 0 flag");

  a_w0_keep: assert property (
    (wr_flags && !reg_req.wdata[0] && !vector_ack.low[0] && low_lines_flags_ff[0]
     && low_sense_ff[1:0] != SENSE_LOW) |=> low_lines_flags_ff[0])
    else $error("write zero cleared line 0 flag");

  a_set_wins: assert property (
    (chg_event && chg_clr) |=> change_group_flag_ff)
    else $error("group flag lost to a same-cycle clear");

  a_chg_request: assert property (
    $rose(irq_req_ff.chg) |-> $past(change_group_flag_ff && change_group_enable_ff
                                    && global_irq_en))
    else $error("group request without flag and enables");

  a_mask_excludes: assert property (
    (pc_mask_ff == 8'h00 && !change_group_flag_ff && !chg_clr) |=> !change_group_flag_ff)
    else $error("masked group pins set the flag");

endmodule // external_pin_interrupts

// File: verification/cpu_pin_model.sv
// Processor-side model: runs a handler for each requested vector and acknowledges it.
// Assumes requests are registered levels on the same clock as the controller.
`timescale 1ns/1ps
module cpu_pin_model
  import ext_irq_pkg::*;
(
  // Clock and reset.
  input  wire logic     clk,
  input  wire logic     resetn,
  // Controller side.
  input  wire irq_vec_t irq_req,
  input  wire logic     auto_ack,
  output irq_vec_t      vector_ack
);
  irq_vec_t ack_ff;
  irq_vec_t hold_ff;

  // The hold register stops a second handler entry while the request is still falling.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_ff  <= irq_vec_t'(6'h00);
      hold_ff <= irq_vec_t'(6'h00);
    end
    else
    begin
      ack_ff  <= auto_ack ? irq_vec_t'(irq_req & ~ack_ff & ~hold_ff) : irq_vec_t'(6'h00);
      hold_ff <= ack_ff;
    end
  end

  assign vector_ack = ack_ff;
endmodule // cpu_pin_model

// File: verification/external_pin_interrupts_bench.sv
// Bench for the pin interrupt controller: registers, sense modes, sleep and change group.
// Assumes the processor model acknowledges vectors while auto_ack is high.
`timescale 1ns/1ps
module external_pin_interrupts_bench;
  import ext_irq_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  reg_req_t   req = '0;
  logic [7:0] rdata_ff;
  logic       l6_pin = 1'b1;
  logic [3:0] low_pins = 4'hF;
  logic [7:0] grp_pins = 8'h00;
  logic       gie = 1'b1;
  logic       io_run = 1'b1;
  logic       sleep = 1'b0;
  logic       auto_ack = 1'b0;
  irq_vec_t   ack;
  irq_vec_t   irq_req;
  logic [7:0] rd_val;
  int         bad_count = 0;
  int         num_checks = 0;
  // Per mode: request and flag after a fall, then after a rise.
  logic [3:0] tbl [4] = '{4'b1000, 4'b1111, 4'b1100, 4'b0011};
  int         lines [5] = '{0, 1, 2, 3, 6};
  logic [3:0] wadr [5] = '{OFS_LOW_SENSE, OFS_L6_SENSE, OFS_ENABLE, OFS_PC_CTRL, OFS_PC_MASK};
  logic [7:0] wexp [5] = '{8'hFF, 8'h30, 8'h4F, 8'h01, 8'hFF};

  always #2 clk = ~clk;

  external_pin_interrupts u_external_pin_interrupts (
    .clk(clk), .resetn(resetn), .reg_req(req), .rdata_ff(rdata_ff),
    .ext_line6_pin(l6_pin), .ext_lines_low_pins(low_pins), .change_group_pins(grp_pins),
    .global_irq_en(gie), .io_clk_run(io_run), .sleep_active(sleep),
    .vector_ack(ack), .irq_req_ff(irq_req));

  cpu_pin_model u_cpu_pin_model (
    .clk(clk), .resetn(resetn), .irq_req(irq_req), .auto_ack(auto_ack), .vector_ack(ack));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    rd_val = rdata_ff;
  endtask

  task automatic pin(input int n, input logic v);
    @(posedge clk);
    if (n == 6)
      l6_pin <= v;
    else
      low_pins[n] <= v;
  endtask

  function automatic logic req_bit(input int n);
    return (n == 6) ? irq_req.line6 : irq_req.low[n];
  endfunction

  // Handler entry clears the flag, so the request must fall within a short bound.
  task automatic wait_drop;
    int i;
    i = 0;
    auto_ack <= 1'b1;
    while (irq_req !== irq_vec_t'(6'h00) && i < 40)
    begin
      cyc(1);
      i++;
    end
    auto_ack <= 1'b0;
    if (irq_req !== irq_vec_t'(6'h00))
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: request never dropped", $time);
      wrap_up();
    end
  endtask

  task automatic sense_case(input int n, input logic [1:0] m, input logic [3:0] f);
    wr(OFS_ENABLE, 8'h00);
    if (n == 6)
      wr(OFS_L6_SENSE, {2'h0, m, 4'h0});
    else
      wr(OFS_LOW_SENSE, {6'h00, m} << (2 * n));
    wr(OFS_FLAGS, 8'h4F);
    wr(OFS_ENABLE, 8'h01 << n);
    pin(n, 1'b0);
    cyc(6);
    check({7'h00, req_bit(n)}, {7'h00, f[3]}, "request after fall");
    rd(OFS_FLAGS);
    check(rd_val, {7'h00, f[2]} << n, "flag after fall");
    wr(OFS_FLAGS, 8'h4F);
    cyc(3);
    check({7'h00, req_bit(n)}, {7'h00, f[3] & ~f[2]}, "request held low");
    pin(n, 1'b1);
    cyc(6);
    check({7'h00, req_bit(n)}, {7'h00, f[1]}, "request after rise");
    rd(OFS_FLAGS);
    check(rd_val, {7'h00, f[0]} << n, "flag after rise");
    wr(OFS_FLAGS, 8'h4F);
  endtask

  initial
  begin
    cyc(6);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      rd(4'(a));
      check(rd_val, 8'h00, "reset value");
    end
    for (int i = 0; i < 5; i++)
    begin
      wr(wadr[i], 8'hFF);
      rd(wadr[i]);
      check(rd_val, wexp[i], "register read back");
    end
    // The last read returned a non-zero mask, so a stale value would show here.
    cyc(1);
    @(negedge clk);
    check(rdata_ff, 8'h00, "read data after its cycle");
    for (int i = 0; i < 5; i++)
      wr(wadr[i], 8'h00);
    for (int i = 0; i < 5; i++)
      for (int m = 0; m < 4; m++)
        sense_case(lines[i], 2'(m), tbl[m]);
    // Line 6 is left in rising mode; with the global enable off only the flag appears.
    gie <= 1'b0;
    wr(OFS_ENABLE, 8'h40);
    pin(6, 1'b0);
    cyc(4);
    pin(6, 1'b1);
    cyc(6);
    check({7'h00, irq_req.line6}, 8'h00, "request with global enable off");
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS);
    check(rd_val, 8'h40, "flag kept after zero write");
    gie <= 1'b1;
    cyc(4);
    check({7'h00, irq_req.line6}, 8'h01, "request from pending flag");
    wait_drop();
    rd(OFS_FLAGS);
    check(rd_val, 8'h00, "flag cleared by handler");
    io_run <= 1'b0;
    pin(6, 1'b0);
    cyc(4);
    pin(6, 1'b1);
    cyc(6);
    rd(OFS_FLAGS);
    check(rd_val, 8'h00, "no edge without clock");
    io_run <= 1'b1;
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_LOW_SENSE, 8'h55);
    wr(OFS_FLAGS, 8'h4F);
    sleep <= 1'b1;
    cyc(6);
    rd(OFS_FLAGS);
    check(rd_val, 8'h0F, "sleep buffer change");
    sleep <= 1'b0;
    cyc(6);
    wr(OFS_FLAGS, 8'h4F);
    wr(OFS_PC_MASK, 8'h02);
    wr(OFS_PC_CTRL, 8'h01);
    grp_pins[0] <= 1'b1;
    cyc(6);
    rd(OFS_PC_FLAG);
    check(rd_val, 8'h00, "masked pin ignored");
    grp_pins[1] <= 1'b1;
    cyc(6);
    check({7'h00, irq_req.chg}, 8'h01, "group request");
    rd(OFS_PC_FLAG);
    check(rd_val, 8'h01, "group flag");
    wr(OFS_PC_FLAG, 8'h01);
    rd(OFS_PC_FLAG);
    check(rd_val, 8'h00, "group flag write clear");
    grp_pins[1] <= 1'b0;
    cyc(6);
    wait_drop();
    rd(OFS_PC_FLAG);
    check(rd_val, 8'h00, "group flag handler clear");
    // The clear strobe lands in the very cycle the change is seen, with the I/O clock halted.
    cyc(1);
    io_run <= 1'b0;
    grp_pins[1] <= 1'b1;
    cyc(1);
    wr(OFS_PC_FLAG, 8'h01);
    rd(OFS_PC_FLAG);
    check(rd_val, 8'h01, "group flag set beats clear");
    io_run <= 1'b1;
    wait_drop();
    wrap_up();
  end
endmodule // external_pin_interrupts_bench
